// ---- hw/fpcr_ctrl_write.sv ----
// fp control register write block with an axi4-lite register slave
//
// The register addresses and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - decode opcode, sub-op, fields, zero low bits
// - low word of operand is write value
// - condition view loads bits 31..25, 23
// - exception view replaces causes and flags
// - enable view loads enables and mode bits
// - full view writes whole register, checked
// - other selectors are unpredictable
// - cause with enable raises fp exception
// - view writes also raise matching exception
// - return pc holds move address
// - only unusable or reserved otherwise
// - six fp exception kinds possible
// - read views map bits, rest zero
module fpcr_ctrl_write
	import fpcr_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// write address channel
	input wire logic awvalid,
	output logic awready,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	// write data channel
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// write response channel
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// read address channel
	input wire logic arvalid,
	output logic arready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	// read data channel
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// exception outputs
	output logic irq,
	output logic fp_exc,
	output logic [5:0] fp_exc_cause,
	output logic [31:0] exception_return_pc
);
	typedef struct packed {
		// software-visible move registers
		logic [31:0] operand;
		logic [31:0] pc;
		logic [31:0] instr;
		logic [31:0] status;
		logic [31:0] exc_pc;
		logic [4:0] view_sel;
		logic [1:0] ctrl;
		// outcome of the last move and interrupt state
		logic [3:0] result;
		logic [5:0] cause;
		logic [2:0] irq_st;
		logic [2:0] irq_mask;
		logic irq;
		logic fp_exc;
		// write channel: captured halves and the held request
		logic aw_got;
		logic w_got;
		logic [ADDR_W-1:0] waddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		fpcr_wr_st_t wst;
		// registered handshake outputs
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} fpcr_state_t;

	localparam fpcr_state_t STATE_RESET = '{
		status: STATUS_RESET,
		ctrl: CTRL_RESET,
		wst: WR_IDLE,
		awready: 1'b1,
		wready: 1'b1,
		arready: 1'b1,
		bresp: RESP_OKAY,
		rresp: RESP_OKAY,
		default: '0
	};

	// state register, its next value and taps from decoder and view
	// awprot and arprot are ignored: no register here is privileged
	fpcr_state_t s;
	fpcr_state_t next_s;
	logic dec_valid;
	logic [4:0] dec_sel;
	logic [31:0] view_status;
	logic view_unpred;
	logic [31:0] view_rd;

	// byte-lane merge for partial writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				r[i*8 +: 8] = d[i*8 +: 8];
		end
		return r;
	endfunction

	// instruction decoder on the held write data
	fpcr_decode u_decode (
		.instr(s.wdata),
		.valid(dec_valid),
		.source_register_field(),
		.control_selector(dec_sel)
	);

	// operand word from the general register feeds the view merge
	fpcr_view u_view (
		.status(s.status),
		.impl_field(s.ctrl[CTRL_IMPL_FIELD]),
		.wr_sel(dec_sel),
		.value(s.operand),
		.new_status(view_status),
		.unpred(view_unpred),
		.rd_sel(s.view_sel),
		.rd_data(view_rd)
	);

	// next-state logic: bus slave, move execution, interrupts
	always_comb
	begin
		logic [5:0] enabled;
		logic [5:0] hit;
		logic trap;
		logic unp;
		logic fpe;
		enabled = 6'h00;
		hit = 6'h00;
		trap = 1'b0;
		unp = 1'b0;
		fpe = 1'b0;
		next_s = s;
		// the exception strobe lasts exactly one cycle
		next_s.fp_exc = 1'b0;
		// address and data are taken in either order
		if (s.awready && awvalid)
		begin
			next_s.aw_got = 1'b1;
			next_s.waddr = awaddr;
		end
		if (s.wready && wvalid)
		begin
			next_s.w_got = 1'b1;
			next_s.wdata = wdata;
			next_s.wstrb = wstrb;
		end
		// register effects happen on the step into the response state
		case (s.wst)
			WR_IDLE:
			begin
				if (s.aw_got && s.w_got)
				begin
					next_s.aw_got = 1'b0;
					next_s.w_got = 1'b0;
					next_s.bvalid = 1'b1;
					next_s.bresp = RESP_OKAY;
					next_s.wst = WR_RESP;
					// register decode; unmapped offsets answer with an error, no effect
					if (s.waddr == OFS_OPERAND)
						next_s.operand = merge(s.operand, s.wdata, s.wstrb);
					else if (s.waddr == OFS_PC)
						next_s.pc = merge(s.pc, s.wdata, s.wstrb);
					else if (s.waddr == OFS_INSTR)
					begin
						// a write here issues one move; it retires in this edge
						next_s.instr = s.wdata;
						next_s.result = 4'h0;
						next_s.result[RES_DONE] = 1'b1;
						// checks in priority order: usable, encoding, reserved bits
						if (!s.ctrl[CTRL_USABLE])
						begin
							next_s.result[RES_UNUSABLE] = 1'b1;
							trap = 1'b1;
						end
						else if (!dec_valid)
						begin
							next_s.result[RES_RESERVED] = 1'b1;
							trap = 1'b1;
						end
						else if (view_unpred)
						begin
							// deterministic choice: keep state, no exception
							next_s.result[RES_UNPRED] = 1'b1;
							unp = 1'b1;
						end
						else
						begin
							// register is written first, then checked
							next_s.status = view_status;
							// unimplemented-op cause has no enable and always traps
							enabled = {1'b1, view_status[ENABLE_HI:ENABLE_LO]};
							hit = view_status[CAUSE_HI:CAUSE_LO] & enabled;
							fpe = |hit;
						end
						// cause and return address change only on an fp exception, so the last one stays readable
						if (fpe)
						begin
							next_s.fp_exc = 1'b1;
							next_s.cause = hit;
							next_s.exc_pc = s.pc;
						end
					end
					else if (s.waddr == OFS_VIEW_SEL)
					begin
						// only the selector bits are kept; the rest reads as zero
						next_s.view_sel = s.wdata[4:0];
					end
					else if (s.waddr == OFS_IRQ_STATUS)
					begin
						// write one to clear; a set in this cycle is applied below and wins
						next_s.irq_st = s.irq_st & ~(s.wdata[2:0] & {3{s.wstrb[0]}});
					end
					else if (s.waddr == OFS_IRQ_MASK)
					begin
						if (s.wstrb[0])
							next_s.irq_mask = s.wdata[2:0];
					end
					else if (s.waddr == OFS_CONTROL)
					begin
						if (s.wstrb[0])
							next_s.ctrl = s.wdata[1:0];
					end
					else if (s.waddr == OFS_STATUS || s.waddr == OFS_VIEW_DATA || s.waddr == OFS_EXC_PC
						|| s.waddr == OFS_RESULT)
						next_s.bresp = RESP_OKAY;
					else
						next_s.bresp = RESP_SLVERR;
				end
			end
			WR_RESP:
			begin
				// response holds until the master takes it
				if (bready)
				begin
					next_s.bvalid = 1'b0;
					next_s.wst = WR_IDLE;
				end
			end
			default:
			begin
				// unreachable codes fall back to idle
				next_s.wst = WR_IDLE;
			end
		endcase
		// sets after the clear so an event is never lost
		if (fpe)
			next_s.irq_st[IRQ_FP_EXC] = 1'b1;
		if (trap)
			next_s.irq_st[IRQ_TRAP] = 1'b1;
		if (unp)
			next_s.irq_st[IRQ_UNPRED] = 1'b1;
		// level interrupt from the updated flags, so a clear shows next cycle
		next_s.irq = |(next_s.irq_st & next_s.irq_mask);
		// a half is refused once held, and both while a response waits
		next_s.awready = !next_s.aw_got && (next_s.wst == WR_IDLE);
		next_s.wready = !next_s.w_got && (next_s.wst == WR_IDLE);
		// read channel: one outstanding read
		if (s.arready && arvalid)
		begin
			next_s.arready = 1'b0;
			next_s.rvalid = 1'b1;
			next_s.rresp = RESP_OKAY;
			// unmapped bits and unknown offsets read as zero
			next_s.rdata = 32'h0000_0000;
			if (araddr == OFS_OPERAND)
				next_s.rdata = s.operand;
			else if (araddr == OFS_PC)
				next_s.rdata = s.pc;
			else if (araddr == OFS_INSTR)
				next_s.rdata = s.instr;
			else if (araddr == OFS_STATUS)
				next_s.rdata = s.status;
			else if (araddr == OFS_VIEW_SEL)
				next_s.rdata[4:0] = s.view_sel;
			else if (araddr == OFS_VIEW_DATA)
				next_s.rdata = view_rd;
			else if (araddr == OFS_EXC_PC)
				next_s.rdata = s.exc_pc;
			else if (araddr == OFS_RESULT)
				next_s.rdata = {22'h00_0000, s.cause, s.result};
			else if (araddr == OFS_IRQ_STATUS)
				next_s.rdata[2:0] = s.irq_st;
			else if (araddr == OFS_IRQ_MASK)
				next_s.rdata[2:0] = s.irq_mask;
			else if (araddr == OFS_CONTROL)
				next_s.rdata[1:0] = s.ctrl;
			else
				next_s.rresp = RESP_SLVERR;
		end
		else if (s.rvalid && rready)
		begin
			next_s.rvalid = 1'b0;
			next_s.arready = 1'b1;
		end
	end

	// single state register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s <= STATE_RESET;
		else
			s <= next_s;
	end

	// outputs straight from the state register
	assign awready = s.awready;
	assign wready = s.wready;
	assign bvalid = s.bvalid;
	assign bresp = s.bresp;
	assign arready = s.arready;
	assign rvalid = s.rvalid;
	assign rdata = s.rdata;
	assign rresp = s.rresp;
	assign irq = s.irq;
	assign fp_exc = s.fp_exc;
	assign fp_exc_cause = s.cause;
	assign exception_return_pc = s.exc_pc;
endmodule
`default_nettype wire

// ---- hw/fpcr_decode.sv ----
// decoder for the move-to-fp-control instruction word
`timescale 1ns/100ps
`default_nettype none
module fpcr_decode
	import fpcr_pkg::*;
(
	// instruction word
	input wire logic [31:0] instr,
	// decoded fields
	output logic valid,
	output logic [4:0] source_register_field,
	output logic [4:0] control_selector
);
	// opcode, sub-operation and zero low field must all match
	assign valid = (instr[31:26] == FP_COPROCESSOR_OPCODE) && (instr[25:21] == MOVE_TO_CONTROL_SUBOP)
		&& (instr[10:0] == LOW_FIELD_ZERO);
	assign source_register_field = instr[20:16];
	assign control_selector = instr[15:11];
endmodule
`default_nettype wire

// ---- hw/fpcr_pkg.sv ----
// constants and types shared by the fp control register write block
package fpcr_pkg;
	// instruction fields
	localparam logic [5:0] FP_COPROCESSOR_OPCODE = 6'h11;
	localparam logic [4:0] MOVE_TO_CONTROL_SUBOP = 5'h06;
	localparam logic [10:0] LOW_FIELD_ZERO = 11'h000;
	// control selectors
	localparam logic [4:0] SEL_IMPL = 5'h00;
	localparam logic [4:0] SEL_COND = 5'h19;
	localparam logic [4:0] SEL_EXC = 5'h1A;
	localparam logic [4:0] SEL_ENA = 5'h1C;
	localparam logic [4:0] SEL_FULL = 5'h1F;
	// implementation register value, arbitrary neutral code
	localparam logic [31:0] FP_IMPL_VALUE = 32'h0000_0100;
	// register byte offsets on the bus
	localparam int ADDR_W = 6;
	localparam logic [ADDR_W-1:0] OFS_OPERAND = 6'h00;
	localparam logic [ADDR_W-1:0] OFS_PC = 6'h04;
	localparam logic [ADDR_W-1:0] OFS_INSTR = 6'h08;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h0C;
	localparam logic [ADDR_W-1:0] OFS_VIEW_SEL = 6'h10;
	localparam logic [ADDR_W-1:0] OFS_VIEW_DATA = 6'h14;
	localparam logic [ADDR_W-1:0] OFS_EXC_PC = 6'h18;
	localparam logic [ADDR_W-1:0] OFS_RESULT = 6'h1C;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 6'h20;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 6'h24;
	localparam logic [ADDR_W-1:0] OFS_CONTROL = 6'h28;
	// control register bits
	localparam int CTRL_USABLE = 0;
	localparam int CTRL_IMPL_FIELD = 1;
	localparam logic [1:0] CTRL_RESET = 2'h1;
	// result register bits
	localparam int RES_DONE = 0;
	localparam int RES_UNPRED = 1;
	localparam int RES_RESERVED = 2;
	localparam int RES_UNUSABLE = 3;
	// interrupt status bits
	localparam int IRQ_FP_EXC = 0;
	localparam int IRQ_TRAP = 1;
	localparam int IRQ_UNPRED = 2;
	// status register fields: causes 17..12, enables 11..7
	localparam int CAUSE_HI = 17;
	localparam int CAUSE_LO = 12;
	localparam int ENABLE_HI = 11;
	localparam int ENABLE_LO = 7;
	localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		WR_IDLE = 2'h1,
		WR_RESP = 2'h2
	} fpcr_wr_st_t;
endpackage

// ---- hw/fpcr_view.sv ----
// view mapping of the fp status register for writes and read-back
`timescale 1ns/100ps
`default_nettype none
module fpcr_view
	import fpcr_pkg::*;
(
	// current state
	input wire logic [31:0] status,
	input wire logic impl_field,
	// write side
	input wire logic [4:0] wr_sel,
	input wire logic [31:0] value,
	output logic [31:0] new_status,
	output logic unpred,
	// read side
	input wire logic [4:0] rd_sel,
	output logic [31:0] rd_data
);
	// write merge per view; unknown selector leaves the register alone
	always_comb
	begin
		new_status = status;
		unpred = 1'b0;
		if (wr_sel == SEL_COND)
		begin
			unpred = |value[31:8];
			new_status[31:25] = value[7:1];
			new_status[23] = value[0];
		end
		else if (wr_sel == SEL_EXC)
		begin
			unpred = |{value[31:18], value[11:7], value[2:0]};
			new_status[17:12] = value[17:12];
			new_status[6:2] = value[6:2];
		end
		else if (wr_sel == SEL_ENA)
		begin
			unpred = |{value[31:12], value[6:3]};
			new_status[24] = value[2];
			new_status[11:7] = value[11:7];
			new_status[1:0] = value[1:0];
		end
		else if (wr_sel == SEL_FULL)
		begin
			unpred = impl_field ? |value[20:18] : |value[22:18];
			new_status = value;
		end
		else
		begin
			unpred = 1'b1;
		end
	end
	// read-back views, unmapped bits zero
	always_comb
	begin
		rd_data = 32'h0000_0000;
		if (rd_sel == SEL_IMPL)
			rd_data = FP_IMPL_VALUE;
		else if (rd_sel == SEL_COND)
			rd_data = {24'h00_0000, status[31:25], status[23]};
		else if (rd_sel == SEL_EXC)
			rd_data = {14'h0000, status[17:12], 5'h00, status[6:2], 2'h0};
		else if (rd_sel == SEL_ENA)
			rd_data = {20'h0_0000, status[11:7], 4'h0, status[24], status[1:0]};
		else if (rd_sel == SEL_FULL)
			rd_data = status;
	end
endmodule
`default_nettype wire

// ---- sim/fpcr_ctrl_write_bench.sv ----
// self-checking bench for the fp control register write block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin failures++; \
	$display("wrong value at %0t got %h expected %h", $time, a, e); end end
module fpcr_ctrl_write_bench
	import fpcr_pkg::*;
;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, irq, fp_exc;
	logic [5:0] awaddr, araddr, fp_exc_cause;
	logic [31:0] wdata, rdata, exception_return_pc, d;
	logic [1:0] bresp, rresp, r;
	int exc_count = 0;
	int failures = 0;
	int check_count = 0;
	// protection and strobes are not exercised here
	fpcr_ctrl_write dut (
		.aclk(aclk), .aresetn(aresetn),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF),
		.bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.irq(irq), .fp_exc(fp_exc), .fp_exc_cause(fp_exc_cause), .exception_return_pc(exception_return_pc)
	);
	fpcr_pipe_model pm (
		.aclk(aclk),
		.awvalid(awvalid), .awaddr(awaddr), .wvalid(wvalid), .wdata(wdata), .bready(bready),
		.awready(awready), .wready(wready), .bvalid(bvalid),
		.arvalid(arvalid), .araddr(araddr), .rready(rready),
		.arready(arready), .rvalid(rvalid), .rdata(rdata), .rresp(rresp)
	);
	initial forever #25 aclk = ~aclk;
	// the pulse is short, so count pulses and compare the count
	always @(posedge aclk) if (fp_exc === 1'b1) exc_count <= exc_count + 1;
	task tally_and_finish(input int hung);
		failures += hung;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task ck(input logic [5:0] a, input logic [31:0] e);
		pm.rd(a, d, r);
		`CHK(d, e)
	endtask
	// one move: operand, its address, then the instruction word
	task mv(input logic [4:0] s, input logic [31:0] v, input logic [10:0] lo);
		pm.wr(OFS_OPERAND, v);
		pm.wr(OFS_PC, {27'h000_0200, s});
		pm.wr(OFS_INSTR, {FP_COPROCESSOR_OPCODE, MOVE_TO_CONTROL_SUBOP, 5'h03, s, lo});
	endtask
	logic [4:0] bad_sel [5] = '{SEL_COND, SEL_EXC, SEL_ENA, 5'h1B, SEL_FULL};
	logic [31:0] bad_val [5] = '{32'h100, 32'h1, 32'h8, 32'h0, 32'h0004_0000};
	initial
	begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		// control comes out of reset with the coprocessor usable
		ck(OFS_CONTROL, 32'h0000_0001);
		`CHK(rresp, RESP_OKAY)
		pm.wr(OFS_IRQ_MASK, 32'h7);
		`CHK(bresp, RESP_OKAY)
		mv(SEL_FULL, 32'h0, 11'h0);
		ck(OFS_STATUS, 32'h0);
		mv(SEL_COND, 32'hFF, 11'h0);
		ck(OFS_STATUS, 32'hFE80_0000);
		// flags 6..3 only: bit 2 of this view is also a reserved check bit
		mv(SEL_EXC, 32'h0001_F078, 11'h0);
		ck(OFS_STATUS, 32'hFE81_F078);
		`CHK(exc_count, 0)
		mv(SEL_ENA, 32'h0F83, 11'h0);
		ck(OFS_STATUS, 32'hFE81_FFFB);
		`CHK(exc_count, 1)
		ck(OFS_EXC_PC, 32'h401C);
		`CHK(exception_return_pc, 32'h0000_401C)
		`CHK(fp_exc_cause, 6'h1F)
		`CHK(irq, 1'b1)
		pm.wr(OFS_IRQ_STATUS, 32'h7);
		`CHK(irq, 1'b0)
		// read-back of the enable, condition, exception and implementation views
		pm.wr(OFS_VIEW_SEL, 32'(SEL_ENA));
		ck(OFS_VIEW_DATA, 32'h0F83);
		pm.wr(OFS_VIEW_SEL, 32'(SEL_COND));
		ck(OFS_VIEW_DATA, 32'hFF);
		pm.wr(OFS_VIEW_SEL, 32'(SEL_EXC));
		ck(OFS_VIEW_DATA, 32'h0001_F078);
		pm.wr(OFS_VIEW_SEL, 32'(SEL_IMPL));
		ck(OFS_VIEW_DATA, FP_IMPL_VALUE);
		// reserved bits or unknown selector leave the register alone
		for (int i = 0; i < 5; i++)
		begin
			mv(bad_sel[i], bad_val[i], 11'h0);
			ck(OFS_STATUS, 32'hFE81_FFFB);
			pm.rd(OFS_RESULT, d, r);
			`CHK(d[RES_UNPRED], 1'b1)
		end
		`CHK(exc_count, 1)
		`CHK(irq, 1'b1)
		pm.wr(OFS_IRQ_MASK, 32'h0);
		`CHK(irq, 1'b0)
		mv(SEL_FULL, 32'h0, 11'h001);
		pm.rd(OFS_RESULT, d, r);
		`CHK(d[RES_RESERVED], 1'b1)
		pm.wr(OFS_CONTROL, 32'h0);
		mv(SEL_FULL, 32'h0, 11'h0);
		pm.rd(OFS_RESULT, d, r);
		`CHK(d[RES_UNUSABLE], 1'b1)
		ck(OFS_STATUS, 32'hFE81_FFFB);
		// full write with its own cause and enable traps at once
		pm.wr(OFS_CONTROL, 32'h3);
		mv(SEL_FULL, 32'h0020_1080, 11'h0);
		ck(OFS_STATUS, 32'h0020_1080);
		`CHK(exc_count, 2)
		`CHK(fp_exc_cause, 6'h01)
		`CHK(exception_return_pc, 32'h0000_401F)
		pm.rd(6'h3C, d, r);
		`CHK(r, RESP_SLVERR)
		pm.wr(6'h3C, 32'h0);
		`CHK(bresp, RESP_SLVERR)
		tally_and_finish(0);
	end
endmodule
`default_nettype wire

// ---- sim/fpcr_pipe_model.sv ----
// pipeline model issuing register accesses as an axi4-lite master
`timescale 1ns/100ps
`default_nettype none
module fpcr_pipe_model
(
	// clock
	input wire logic aclk,
	// write side
	output logic awvalid,
	output logic [5:0] awaddr,
	output logic wvalid,
	output logic [31:0] wdata,
	output logic bready,
	input wire logic awready,
	input wire logic wready,
	input wire logic bvalid,
	// read side
	output logic arvalid,
	output logic [5:0] araddr,
	output logic rready,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp
);
	// idle bus at time zero
	initial {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
	// one write; each channel released at its own handshake
	task wr(input logic [5:0] a, input logic [31:0] dat);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= dat;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 40; n++)
		begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		if (n == 40) fpcr_ctrl_write_bench.tally_and_finish(1);
	endtask
	// one read; data taken at the rvalid edge
	task rd(input logic [5:0] a, output logic [31:0] dat, output logic [1:0] rs);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 40; n++)
		begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		dat = rdata;
		rs = rresp;
		rready <= 1'b0;
		if (n == 40) fpcr_ctrl_write_bench.tally_and_finish(1);
	endtask
endmodule
`default_nettype wire

// ---- sim/fpcr_wr_properties.sv ----
// port assertions for the fp control register write block
`timescale 1ns/100ps
`default_nettype none
module fpcr_wr_properties
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// bus handshakes
	input wire logic awready,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata,
	// exception outputs
	input wire logic fp_exc,
	input wire logic [5:0] fp_exc_cause
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// response channels hold until taken
	a_b_holds: assert property (bvalid && !bready |=> bvalid) else $error("write response dropped");
	a_w_blocked: assert property (bvalid |-> !awready && !wready) else $error("write taken while busy");
	a_r_answer: assert property (arvalid && arready |=> rvalid) else $error("read not answered");
	a_rdata_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("read data moved");
	a_ar_blocked: assert property (rvalid |-> !arready) else $error("read taken while busy");
	// exception raised with the move's write response, single cycle
	a_exc_at_move: assert property (fp_exc |-> $rose(bvalid)) else $error("exception off the move");
	a_exc_pulse: assert property (fp_exc |=> !fp_exc) else $error("exception not a pulse");
	a_exc_cause: assert property (fp_exc |-> fp_exc_cause != 6'h00) else $error("exception without cause");
	a_cause_moves: assert property ($changed(fp_exc_cause) |-> fp_exc) else $error("cause moved alone");
endmodule
bind fpcr_ctrl_write fpcr_wr_properties u_props (
	.aclk(aclk),
	.aresetn(aresetn),
	.awready(awready),
	.wready(wready),
	.bvalid(bvalid),
	.bready(bready),
	.arvalid(arvalid),
	.arready(arready),
	.rvalid(rvalid),
	.rready(rready),
	.rdata(rdata),
	.fp_exc(fp_exc),
	.fp_exc_cause(fp_exc_cause)
);
`default_nettype wire
